// >>> verilog/mlt_table.sv
// What this block does
// [R1] each frame's egress ports come from a lookup of its destination_address.
// [R2] entries map address plus vlan to ports, tagged static or dynamic, in one table.
// [R3] management creates static entries from address, vlan and target port.
// [R4] each frame's sender_address inserts or refreshes a dynamic entry on the ingress port; the code skips it on a filter hit or in a cycle with a command.
// [R5] a dynamic entry is deleted after a full aging period without its sender.
// [R6] the aging period is 300 seconds after reset.
// [R7] only aging periods of 10 to 630 seconds are accepted.
// [R8] readout walks entries ordered by vlan, then by address.
// [R9] frames hitting a filter entry (address, vlan 1 to 4094) are discarded.
// [R10] flush removes all dynamic entries at once and keeps static ones.
// [R11] promote turns a dynamic entry into a static one with the same contents.
// [R12] readout reports address, vlan, ports and the entry type.
// [R13] readout starts at the first entry at or after a given key.
// [R14] delete removes only the named entry.
// [R15] static and filter entries never age and are never overwritten by learning.
// [R16] an unknown destination floods to the vlan's ports except the ingress.
module mlt_table #(
   parameter int DEPTH      = 16,                   // table entries
   parameter int SEC_CYCLES = mlt_pkg::SEC_CYCLES   // clocks per second
) (
   input  wire logic                       mclk,         // core clock
   input  wire logic                       rst,          // sync reset
   input  wire logic                       frm_valid,    // frame header present
   input  wire mlt_pkg::mlt_frame_t        frm,          // frame header
   input  wire logic                       cmd_valid,    // management command
   input  wire mlt_pkg::mlt_cmd_t          cmd,          // command fields
   input  wire logic                       age_wr,       // aging write strobe
   input  wire logic [mlt_pkg::AGEW-1:0]   age_secs,     // new aging period
   output logic                            fwd_valid,    // forward answer
   output logic [mlt_pkg::NPORTS-1:0]      fwd_ports,    // egress set
   output logic                            fwd_drop,     // frame discarded
   output logic                            fwd_known,    // destination found
   output logic                            cmd_done,     // command answered
   output logic                            cmd_ok,       // command succeeded
   output logic                            rd_hit,       // readout found entry
   output mlt_pkg::mlt_rd_t                rd_data,      // readout entry
   output logic [mlt_pkg::AGEW-1:0]        age_period    // current period
);
   localparam int IW = $clog2(DEPTH);
   localparam int CW = $clog2(SEC_CYCLES);
   localparam int KW = mlt_pkg::VW + mlt_pkg::AW;

   // -----------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------
   if (DEPTH < 2 || SEC_CYCLES < 2) begin : g_bad
      $error("mlt_table: DEPTH and SEC_CYCLES must be at least 2");
   end

   // -----------------------------------------------------------
   // table storage and per-entry matching
   // -----------------------------------------------------------
   mlt_pkg::mlt_entry_t ent_q [DEPTH];
   logic [KW-1:0]       key_w [DEPTH];
   logic [DEPTH-1:0]    val_v, c_m, d_m, f_m, s_m, ge_v, nd_v;
   logic [KW-1:0]       ckey, dkey, skey;
   logic [mlt_pkg::NPORTS-1:0] ing_oh;

   assign ckey   = {cmd.vlan, cmd.addr};
   assign dkey   = {frm.vlan, frm.destination_address};
   assign skey   = {frm.vlan, frm.sender_address};
   assign ing_oh = {{(mlt_pkg::NPORTS-1){1'b0}}, 1'b1} << frm.in_port;

   function automatic logic [IW-1:0] first_idx(input logic [DEPTH-1:0] v);
      logic [IW-1:0] r;
      r = '0;
      for (int i = DEPTH-1; i >= 0; i--) begin
         if (v[i]) begin
            r = IW'(i);
         end
      end
      return r;
   endfunction : first_idx

   // -----------------------------------------------------------
   // shared decisions
   // -----------------------------------------------------------
   logic          tick_q;
   logic          key_ok, c_any, fr_any, s_any, learn_go, is_rd;
   logic [IW-1:0] c_idx, fr_idx, s_idx, d_idx, wr_idx, ln_idx, rd_idx;
   logic          rd_found;

   // vlan 0 and 4095 are not legal keys for management
   assign key_ok = cmd.vlan >= mlt_pkg::VID_MIN && cmd.vlan <= mlt_pkg::VID_MAX; // R9
   assign c_any  = |c_m;
   assign c_idx  = first_idx(c_m);
   assign fr_any = |(~val_v);
   assign fr_idx = first_idx(~val_v);
   assign s_any  = |s_m;
   assign s_idx  = first_idx(s_m);
   assign d_idx  = first_idx(d_m);
   assign wr_idx = c_any ? c_idx : fr_idx;
   assign ln_idx = s_any ? s_idx : fr_idx;
   assign is_rd  = cmd.op == mlt_pkg::OP_READ_GE || cmd.op == mlt_pkg::OP_READ_GT;

   // learning yields to any command so one slot never gets two writers
   assign learn_go = frm_valid && !cmd_valid && !(|f_m) &&
                     (s_any ? ent_q[s_idx].kind == mlt_pkg::K_DYN : fr_any); // R4 R15

   // smallest key in the readout window; vlan is the upper 12 key bits
   always_comb begin
      rd_found = 1'b0;
      rd_idx   = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (ge_v[i] && (!rd_found || key_w[i] < key_w[rd_idx])) begin // R8
            rd_found = 1'b1;
            rd_idx   = IW'(i);
         end
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_ent
      logic is_dyn;
      assign is_dyn   = ent_q[g].kind == mlt_pkg::K_DYN;
      assign key_w[g] = {ent_q[g].vlan, ent_q[g].addr};
      assign val_v[g] = ent_q[g].valid;
      assign nd_v[g]  = ent_q[g].valid && !is_dyn;
      assign c_m[g]   = ent_q[g].valid && key_w[g] == ckey;
      assign s_m[g]   = ent_q[g].valid && key_w[g] == skey;
      assign d_m[g]   = ent_q[g].valid && key_w[g] == dkey &&
                        ent_q[g].kind != mlt_pkg::K_FILT; // R1
      assign f_m[g]   = ent_q[g].valid && ent_q[g].kind == mlt_pkg::K_FILT &&
                        (key_w[g] == dkey || key_w[g] == skey); // R9
      assign ge_v[g]  = ent_q[g].valid && (cmd.op == mlt_pkg::OP_READ_GT ?
                        key_w[g] > ckey : key_w[g] >= ckey); // R13

      // one writer per entry: command, then learning, then aging
      always_ff @(posedge mclk) begin
         if (rst) begin
            ent_q[g] <= '0;
         end else if (cmd_valid && cmd.op == mlt_pkg::OP_FLUSH) begin
            if (is_dyn) begin
               ent_q[g].valid <= 1'b0; // R10
            end
         end else if (cmd_valid && key_ok && wr_idx == IW'(g)) begin
            case (cmd.op)
               mlt_pkg::OP_ADD_STAT, mlt_pkg::OP_ADD_FILT: begin
                  if (c_any || fr_any) begin
                     ent_q[g].valid <= 1'b1; // R2 R3
                     ent_q[g].kind  <= cmd.op == mlt_pkg::OP_ADD_STAT ?
                                       mlt_pkg::K_STAT : mlt_pkg::K_FILT;
                     ent_q[g].addr  <= cmd.addr;
                     ent_q[g].vlan  <= cmd.vlan;
                     ent_q[g].ports <= cmd.op == mlt_pkg::OP_ADD_STAT ?
                                       cmd.ports : '0;
                     ent_q[g].age   <= '0;
                  end
               end
               mlt_pkg::OP_DELETE: begin
                  if (c_any) begin
                     ent_q[g].valid <= 1'b0; // R14
                  end
               end
               mlt_pkg::OP_PROMOTE: begin
                  if (c_any && is_dyn) begin
                     ent_q[g].kind <= mlt_pkg::K_STAT; // R11
                  end
               end
               default: begin
               end
            endcase
         end else if (learn_go && ln_idx == IW'(g)) begin
            ent_q[g].valid <= 1'b1; // R4
            ent_q[g].kind  <= mlt_pkg::K_DYN;
            ent_q[g].addr  <= frm.sender_address;
            ent_q[g].vlan  <= frm.vlan;
            ent_q[g].ports <= ing_oh;
            ent_q[g].age   <= '0;
         end else if (tick_q && ent_q[g].valid && is_dyn) begin
            // age counts whole ticks; dying one tick past the period keeps a
            // silent sender for at least a full period, at most one second more
            if (ent_q[g].age >= age_period) begin
               ent_q[g].valid <= 1'b0; // R5 R15
            end else begin
               ent_q[g].age <= ent_q[g].age + 1'b1;
            end
         end
      end
   end

   // -----------------------------------------------------------
   // one-second tick and aging period
   // -----------------------------------------------------------
   logic [CW-1:0] sec_cnt_q;

   always_ff @(posedge mclk) begin
      if (rst || sec_cnt_q == CW'(SEC_CYCLES - 1)) begin
         sec_cnt_q <= '0;
      end else begin
         sec_cnt_q <= sec_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      tick_q <= !rst && sec_cnt_q == CW'(SEC_CYCLES - 1);
   end

   // out-of-range writes are dropped, the old period stays
   always_ff @(posedge mclk) begin
      if (rst) begin
         age_period <= mlt_pkg::AGE_RST; // R6
      end else if (age_wr && age_secs >= mlt_pkg::AGE_MIN &&
                   age_secs <= mlt_pkg::AGE_MAX) begin
         age_period <= age_secs; // R7
      end
   end

   // -----------------------------------------------------------
   // forwarding answer
   // -----------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         fwd_valid <= 1'b0;
         fwd_drop  <= 1'b0;
         fwd_known <= 1'b0;
         fwd_ports <= '0;
      end else begin
         fwd_valid <= frm_valid;
         fwd_drop  <= frm_valid && (|f_m); // R9
         fwd_known <= frm_valid && (|d_m);
         if (!frm_valid || (|f_m)) begin
            fwd_ports <= '0;
         end else if (|d_m) begin
            fwd_ports <= ent_q[d_idx].ports & ~ing_oh; // R1
         end else begin
            fwd_ports <= frm.vlan_ports & ~ing_oh; // R16
         end
      end
   end

   // -----------------------------------------------------------
   // command answer and readout
   // -----------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_done <= 1'b0;
         cmd_ok   <= 1'b0;
         rd_hit   <= 1'b0;
         rd_data  <= '0;
      end else begin
         cmd_done <= cmd_valid;
         rd_hit   <= cmd_valid && is_rd && rd_found;
         case (cmd.op)
            mlt_pkg::OP_ADD_STAT,
            mlt_pkg::OP_ADD_FILT: cmd_ok <= cmd_valid && key_ok && (c_any || fr_any);
            mlt_pkg::OP_DELETE:   cmd_ok <= cmd_valid && key_ok && c_any;
            mlt_pkg::OP_PROMOTE:  cmd_ok <= cmd_valid && key_ok && c_any &&
                                           ent_q[c_idx].kind == mlt_pkg::K_DYN;
            mlt_pkg::OP_FLUSH:    cmd_ok <= cmd_valid;
            default:              cmd_ok <= cmd_valid && rd_found;
         endcase
         if (cmd_valid && is_rd) begin
            rd_data <= '{kind:  ent_q[rd_idx].kind, // R12
                         addr:  ent_q[rd_idx].addr,
                         vlan:  ent_q[rd_idx].vlan,
                         ports: ent_q[rd_idx].ports};
         end
      end
   end

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic [IW:0]                nd_cnt;
   logic                       dyn_any;
   logic [mlt_pkg::NPORTS-1:0] flood_w;
   assign nd_cnt  = (IW+1)'($countones(nd_v));
   assign dyn_any = |(val_v & ~nd_v);
   assign flood_w = frm.vlan_ports & ~ing_oh;

   sequence s_miss;
      frm_valid && !(|d_m) && !(|f_m);
   endsequence
   sequence s_read_gt;
      cmd_valid && cmd.op == mlt_pkg::OP_READ_GT;
   endsequence
   sequence s_flush;
      cmd_valid && cmd.op == mlt_pkg::OP_FLUSH;
   endsequence

   a_fwd_answer: assert property (frm_valid |=> fwd_valid ##1 !fwd_valid || $past(frm_valid)) // R1
      else $error("forward answer missing");
   a_filter_drop: assert property (frm_valid && (|f_m) |=> fwd_drop && fwd_ports == '0) // R9
      else $error("filtered frame not dropped");
   a_flood_miss: assert property (s_miss |=> fwd_ports == $past(flood_w) && !fwd_known) // R16
      else $error("unknown destination not flooded");
   a_age_reset: assert property ($fell(rst) |-> age_period == mlt_pkg::AGE_RST) // R6
      else $error("aging period not 300 after reset");
   a_age_range: assert property (age_period >= mlt_pkg::AGE_MIN &&
                                 age_period <= mlt_pkg::AGE_MAX) // R7
      else $error("aging period out of range");
   a_flush_dyn: assert property (s_flush |=> !dyn_any && nd_cnt == $past(nd_cnt)) // R10
      else $error("flush left dynamic entry or lost static");
   a_static_keep: assert property (!cmd_valid |=> nd_cnt == $past(nd_cnt)) // R15
      else $error("static entry changed without command");
   a_read_order: assert property (s_read_gt |=> !rd_hit || {rd_data.vlan, rd_data.addr} >
                                  $past(ckey)) // R8
      else $error("readout not past key");
   a_learn_hit: assert property (learn_go |=> val_v[$past(ln_idx)] && // R4
                                 key_w[$past(ln_idx)] == $past(skey) &&
                                 ent_q[$past(ln_idx)].ports == $past(ing_oh))
      else $error("sender not learned");
endmodule : mlt_table

// >>> verilog/mlt_pkg.sv
package mlt_pkg;
   // -----------------------------------------------------------
   // widths
   // -----------------------------------------------------------
   localparam int NPORTS = 8;
   localparam int PW     = 3;              // port index width
   localparam int AW     = 48;
   localparam int VW     = 12;
   localparam int AGEW   = 10;

   // -----------------------------------------------------------
   // aging and key limits
   // -----------------------------------------------------------
   localparam logic [AGEW-1:0] AGE_RST = 10'h12C;   // 300 s
   localparam logic [AGEW-1:0] AGE_MIN = 10'h00A;   // 10 s
   localparam logic [AGEW-1:0] AGE_MAX = 10'h276;   // 630 s
   localparam logic [VW-1:0]   VID_MIN = 12'h001;
   localparam logic [VW-1:0]   VID_MAX = 12'hFFE;   // 4094

   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int AGE_TICK_S    = 1;
   localparam int SEC_CYCLES    = AGE_TICK_S * 1_000_000_000 / CLK_PERIOD_NS;

   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      K_DYN  = 2'h0,
      K_STAT = 2'h1,
      K_FILT = 2'h2
   } mlt_kind_t;

   typedef enum logic [2:0] {
      OP_ADD_STAT = 3'h0,
      OP_ADD_FILT = 3'h1,
      OP_DELETE   = 3'h2,
      OP_FLUSH    = 3'h3,
      OP_PROMOTE  = 3'h4,
      OP_READ_GE  = 3'h5,
      OP_READ_GT  = 3'h6
   } mlt_op_t;

   typedef struct packed {
      logic [AW-1:0]     destination_address;
      logic [AW-1:0]     sender_address;
      logic [VW-1:0]     vlan;
      logic [PW-1:0]     in_port;
      logic [NPORTS-1:0] vlan_ports;       // members of the frame's vlan
   } mlt_frame_t;

   typedef struct packed {
      mlt_op_t           op;
      logic [AW-1:0]     addr;
      logic [VW-1:0]     vlan;
      logic [NPORTS-1:0] ports;
   } mlt_cmd_t;

   typedef struct packed {
      logic              valid;
      mlt_kind_t         kind;
      logic [AW-1:0]     addr;
      logic [VW-1:0]     vlan;
      logic [NPORTS-1:0] ports;
      logic [AGEW-1:0]   age;
   } mlt_entry_t;

   typedef struct packed {
      mlt_kind_t         kind;
      logic [AW-1:0]     addr;
      logic [VW-1:0]     vlan;
      logic [NPORTS-1:0] ports;
   } mlt_rd_t;
endpackage : mlt_pkg

// >>> verification/mlt_mgmt_model.sv
// -----------------------------------------------------------
// forwarding pipeline and management processor stand-in
// -----------------------------------------------------------
module mlt_mgmt_model (
   input  wire logic                     mclk,       // core clock
   output mlt_pkg::mlt_frame_t           frm,        // frame header to the table
   output logic                          frm_valid,  // frame strobe
   output mlt_pkg::mlt_cmd_t             cmd,        // command fields
   output logic                          cmd_valid,  // command strobe
   output logic                          age_wr,     // aging write strobe
   output logic [mlt_pkg::AGEW-1:0]      age_secs    // aging period value
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle levels at time zero, before any request
   initial begin
      frm       = '0;
      frm_valid = 1'b0;
      cmd       = '0;
      cmd_valid = 1'b0;
      age_wr    = 1'b0;
      age_secs  = '0;
   end

   // one frame header, held for exactly the taking edge, then scrambled
   // so that nothing can lean on a stale header after release
   task automatic send_frame(input logic [47:0] dst, input logic [47:0] src,
                             input logic [11:0] vl, input logic [2:0] ip,
                             input logic [7:0] vp);
      @(posedge mclk);
      #1;
      frm       = {dst, src, vl, ip, vp};
      frm_valid = 1'b1;
      @(posedge mclk);
      #1;
      frm_valid = 1'b0;
      frm       = ~frm;
   endtask : send_frame

   // one command; a static add carries address, vlan and target port
   task automatic send_cmd(input mlt_pkg::mlt_op_t o, input logic [47:0] a,
                           input logic [11:0] vl, input logic [7:0] p);
      @(posedge mclk);
      #1;
      cmd       = {o, a, vl, p};
      cmd_valid = 1'b1;
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      cmd       = ~cmd;
   endtask : send_cmd

   // aging write; only refusal scenarios hand in values outside 10..630
   task automatic set_age(input logic [9:0] s);
      @(posedge mclk);
      #1;
      age_secs = s;
      age_wr   = 1'b1;
      @(posedge mclk);
      #1;
      age_wr   = 1'b0;
      age_secs = ~age_secs;
   endtask : set_age
endmodule : mlt_mgmt_model

// >>> verification/mlt_table_tb_top.sv
module mlt_table_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SC = 10;                 // one aging second is ten clocks here
   logic                   mclk;
   logic                   rst;
   mlt_pkg::mlt_frame_t    frm;
   logic                   frm_valid;
   mlt_pkg::mlt_cmd_t      cmd;
   logic                   cmd_valid;
   logic                   age_wr;
   logic [9:0]             age_secs;
   logic                   fwd_valid;
   logic [7:0]             fwd_ports;
   logic                   fwd_drop;
   logic                   fwd_known;
   logic                   cmd_done;
   logic                   cmd_ok;
   logic                   rd_hit;
   mlt_pkg::mlt_rd_t       rd_data;
   logic [9:0]             age_period;
   int                     err_total;
   int                     n_checks;

   // -----------------------------------------------------------
   // clock, design and far side
   // -----------------------------------------------------------
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   mlt_table #(.DEPTH(16), .SEC_CYCLES(SC)) mlt_table_i (
      .mclk(mclk), .rst(rst), .frm_valid(frm_valid), .frm(frm),
      .cmd_valid(cmd_valid), .cmd(cmd), .age_wr(age_wr), .age_secs(age_secs),
      .fwd_valid(fwd_valid), .fwd_ports(fwd_ports), .fwd_drop(fwd_drop),
      .fwd_known(fwd_known), .cmd_done(cmd_done), .cmd_ok(cmd_ok),
      .rd_hit(rd_hit), .rd_data(rd_data), .age_period(age_period));

   mlt_mgmt_model mlt_mgmt_model_i (
      .mclk(mclk), .frm(frm), .frm_valid(frm_valid), .cmd(cmd),
      .cmd_valid(cmd_valid), .age_wr(age_wr), .age_secs(age_secs));

   // -----------------------------------------------------------
   // shared helpers
   // -----------------------------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   // six-cycle synchronous reset, empties the table between scenarios
   task automatic do_reset;
      @(posedge mclk);
      #1;
      rst = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      rst = 1'b0;
   endtask : do_reset

   // lookup; the known flag is only judged when the frame is not dropped
   task automatic look(input logic [47:0] dst, input logic [11:0] vl, input logic [2:0] ip,
                       input logic [7:0] xp, input logic kn, input logic dr);
      mlt_mgmt_model_i.send_frame(dst, 48'h0000_0000_0E0E, vl, ip, 8'hFF);
      check("fwd_valid", fwd_valid, 1'b1);
      check("fwd_ports", fwd_ports, xp);
      check("fwd_drop", fwd_drop, dr);
      if (!dr) check("fwd_known", fwd_known, kn);
   endtask : look

   task automatic op(input mlt_pkg::mlt_op_t o, input logic [47:0] a, input logic [11:0] vl,
                     input logic [7:0] p, input logic ok);
      mlt_mgmt_model_i.send_cmd(o, a, vl, p);
      check("cmd_done", cmd_done, 1'b1);
      check("cmd_ok", cmd_ok, ok);
   endtask : op

   task automatic rd(input mlt_pkg::mlt_op_t o, input logic [47:0] a, input logic [11:0] vl,
                     input logic hit, input logic [1:0] k, input logic [47:0] ea,
                     input logic [11:0] ev, input logic [7:0] ep);
      op(o, a, vl, 8'h00, hit);
      check("rd_hit", rd_hit, hit);
      if (hit) begin
         check("rd_kind", rd_data.kind, k);
         check("rd_addr", rd_data.addr, ea);
         check("rd_vlan", rd_data.vlan, ev);
         check("rd_ports", rd_data.ports, ep);
      end
   endtask : rd

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_learn;
      do_reset;
      check("age_period", age_period, 10'h12C);
      look(48'h0000_0000_00A1, 12'h005, 3'h2, 8'hFB, 1'b0, 1'b0);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_00A1, 12'h005, 3'h3, 8'hFF);
      look(48'h0000_0000_00A1, 12'h005, 3'h1, 8'h08, 1'b1, 1'b0);
      look(48'h0000_0000_00A1, 12'h006, 3'h1, 8'hFD, 1'b0, 1'b0);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_00A1, 12'h005, 3'h6, 8'hFF);
      look(48'h0000_0000_00A1, 12'h005, 3'h1, 8'h40, 1'b1, 1'b0);
      look(48'h0000_0000_00A1, 12'h005, 3'h6, 8'h00, 1'b1, 1'b0);
      $display("test learn done");
   endtask : t_learn

   // three entries out of order, walked back in vlan-then-address order
   task automatic t_readout;
      do_reset;
      op(mlt_pkg::OP_ADD_STAT, 48'h0000_0000_0020, 12'h007, 8'h01, 1'b1);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_0010, 12'h007, 3'h3, 8'hFF);
      op(mlt_pkg::OP_ADD_STAT, 48'h0000_0000_0030, 12'h002, 8'h04, 1'b1);
      rd(mlt_pkg::OP_READ_GE, 48'h0, 12'h000, 1'b1, 2'h1, 48'h30, 12'h002, 8'h04);
      rd(mlt_pkg::OP_READ_GT, 48'h30, 12'h002, 1'b1, 2'h0, 48'h10, 12'h007, 8'h08);
      rd(mlt_pkg::OP_READ_GT, 48'h10, 12'h007, 1'b1, 2'h1, 48'h20, 12'h007, 8'h01);
      rd(mlt_pkg::OP_READ_GT, 48'h20, 12'h007, 1'b0, 2'h0, 48'h0, 12'h000, 8'h00);
      rd(mlt_pkg::OP_READ_GE, 48'h20, 12'h007, 1'b1, 2'h1, 48'h20, 12'h007, 8'h01);
      $display("test readout done");
   endtask : t_readout

   task automatic t_manage;
      do_reset;
      op(mlt_pkg::OP_ADD_FILT, 48'h0000_0000_00F0, 12'hFFE, 8'h00, 1'b1);
      op(mlt_pkg::OP_ADD_FILT, 48'h0000_0000_00F1, 12'h000, 8'h00, 1'b0);
      op(mlt_pkg::OP_ADD_FILT, 48'h0000_0000_00F1, 12'hFFF, 8'h00, 1'b0);
      look(48'h0000_0000_00F0, 12'hFFE, 3'h1, 8'h00, 1'b0, 1'b1);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_0051, 12'h003, 3'h1, 8'hFF);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_0052, 12'h003, 3'h2, 8'hFF);
      op(mlt_pkg::OP_PROMOTE, 48'h0000_0000_0051, 12'h003, 8'h00, 1'b1);
      op(mlt_pkg::OP_PROMOTE, 48'h0000_0000_00F0, 12'hFFE, 8'h00, 1'b0);
      op(mlt_pkg::OP_FLUSH, 48'h0, 12'h000, 8'h00, 1'b1);
      rd(mlt_pkg::OP_READ_GE, 48'h51, 12'h003, 1'b1, 2'h1, 48'h51, 12'h003, 8'h02);
      look(48'h0000_0000_0052, 12'h003, 3'h4, 8'hEF, 1'b0, 1'b0);
      op(mlt_pkg::OP_DELETE, 48'h0000_0000_00F0, 12'hFFE, 8'h00, 1'b1);
      op(mlt_pkg::OP_DELETE, 48'h0000_0000_00F0, 12'hFFE, 8'h00, 1'b0);
      look(48'h0000_0000_00F0, 12'hFFE, 3'h1, 8'hFD, 1'b0, 1'b0);
      look(48'h0000_0000_0051, 12'h003, 3'h4, 8'h02, 1'b1, 1'b0);
      $display("test manage done");
   endtask : t_manage

   // short period so a dynamic entry expires well inside the run
   task automatic t_aging;
      do_reset;
      mlt_mgmt_model_i.set_age(10'h009);
      check("age_period", age_period, 10'h12C);
      mlt_mgmt_model_i.set_age(10'h277);
      check("age_period", age_period, 10'h12C);
      mlt_mgmt_model_i.set_age(10'h276);
      check("age_period", age_period, 10'h276);
      mlt_mgmt_model_i.set_age(10'h00A);
      check("age_period", age_period, 10'h00A);
      op(mlt_pkg::OP_ADD_STAT, 48'h0000_0000_0070, 12'h004, 8'h20, 1'b1);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_0071, 12'h004, 3'h1, 8'hFF);
      mlt_mgmt_model_i.send_frame(48'h0000_0000_00B0, 48'h0000_0000_0070, 12'h004, 3'h2, 8'hFF);
      repeat (8 * SC) @(posedge mclk);
      look(48'h0000_0000_0071, 12'h004, 3'h3, 8'h02, 1'b1, 1'b0);
      look(48'h0000_0000_0070, 12'h004, 3'h3, 8'h20, 1'b1, 1'b0);
      // just short of ten seconds of silence: the sender must still be known
      repeat (SC) @(posedge mclk);
      look(48'h0000_0000_0071, 12'h004, 3'h3, 8'h02, 1'b1, 1'b0);
      repeat (4 * SC) @(posedge mclk);
      look(48'h0000_0000_0071, 12'h004, 3'h3, 8'hF7, 1'b0, 1'b0);
      look(48'h0000_0000_0070, 12'h004, 3'h3, 8'h20, 1'b1, 1'b0);
      $display("test aging done");
   endtask : t_aging

   // -----------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------
   initial begin
      rst       = 1'b1;
      err_total = 0;
      n_checks  = 0;
      t_learn;
      t_readout;
      t_manage;
      t_aging;
      print_verdict;
   end

   // the whole run needs well under a thousand clocks
   initial begin
      #100_000;
      err_total++;
      print_verdict;
   end
endmodule : mlt_table_tb_top
